// ===== verilog/fic_host.sv
// host controller that sequences flash id, protect query and command writes
`timescale 1ns/1ns
module fic_host (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire fic_pkg::fic_req_s req_in,
  input  wire logic             req_valid_in,
  input  wire logic             unprotect_in,
  input  wire logic [7:0]       dq_in,
  output logic                  req_ready_out,
  output fic_pkg::fic_pins_s    pins_out,
  output logic                  rst_n_out,
  output logic [7:0]            rd_data_out,
  output logic                  rd_valid_out,
  output logic                  parity_ok_out,
  output logic                  protected_out,
  output logic                  id_mode_out
);
  import fic_pkg::*;

  typedef enum logic [2:0] {
    FIC_IDLE,
    FIC_SETUP,
    FIC_STROBE,
    FIC_HOLD,
    FIC_NEXT
  } fic_state_e;

  fic_state_e       state_reg, state_next;
  fic_req_s         cur_reg, cur_next;
  fic_pins_s        pins_reg, pins_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0]       step_reg, step_next;
  logic [1:0]       nsteps_reg, nsteps_next;
  logic [7:0]       rd_reg, rd_next;
  logic             rdv_reg, rdv_next;
  logic             par_reg, par_next;
  logic             prot_reg, prot_next;
  logic             idm_reg, idm_next;
  logic             rdy_reg, rdy_next;
  logic             rstn_reg, rstn_next;
  logic [7:0]       dq_s1_reg, dq_s2_reg;
  logic             is_read;
  logic [19:0]      step_addr;
  logic [7:0]       step_data;

  // two-stage sync; read only by the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
    end else begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // step address and data of the current bus cycle
  always_comb begin
    is_read   = 1'b1;
    step_addr = cur_reg.addr;
    step_data = cur_reg.data;
    case (cur_reg.op)
      FIC_OP_HV_ID: begin
        step_addr = {19'h00000, cur_reg.addr[BYTE_SEL_BIT]};
      end
      FIC_OP_HV_PROT: begin
        step_addr = {cur_reg.addr[19:SECT_LSB], 13'h0000} | OFS_PROTECT;
      end
      FIC_OP_CMD_ID, FIC_OP_CMD_PROT: begin
        is_read = (step_reg == 2'd3);
        case (step_reg)
          2'd0: begin
            step_addr = UNLOCK1_ADDR;
            step_data = UNLOCK1_DATA;
          end
          2'd1: begin
            step_addr = UNLOCK2_ADDR;
            step_data = UNLOCK2_DATA;
          end
          2'd2: begin
            step_addr = UNLOCK1_ADDR;
            step_data = CMD_IDENT;
          end
          default: begin
            if (cur_reg.op == FIC_OP_CMD_PROT) begin
              step_addr = {cur_reg.addr[19:SECT_LSB], 13'h0000} | OFS_PROTECT;
            end else begin
              step_addr = cur_reg.addr[BYTE_SEL_BIT] ? OFS_DEVICE : OFS_MANUF;
            end
          end
        endcase
      end
      FIC_OP_EXIT_ID: begin
        is_read   = 1'b0;
        step_data = CMD_RESET;
      end
      FIC_OP_WRITE: begin
        is_read = 1'b0;
      end
      default: begin
        is_read = 1'b1;
      end
    endcase
  end

  always_comb begin
    state_next  = state_reg;
    cur_next    = cur_reg;
    pins_next   = pins_reg;
    cnt_next    = cnt_reg;
    step_next   = step_reg;
    nsteps_next = nsteps_reg;
    rd_next     = rd_reg;
    rdv_next    = 1'b0;
    par_next    = par_reg;
    prot_next   = prot_reg;
    idm_next    = idm_reg;
    rdy_next    = rdy_reg;
    rstn_next   = 1'b1;
    pins_next.hv_reset = unprotect_in;
    case (state_reg)
      FIC_IDLE: begin
        pins_next.ce_n      = 1'b1;
        pins_next.oe_n      = 1'b1;
        pins_next.we_n      = 1'b1;
        pins_next.dq_oe_n   = 1'b1;
        pins_next.hv_detect = 1'b0;
        if (req_valid_in && rdy_reg) begin
          cur_next    = req_in;
          rdy_next    = 1'b0;
          step_next   = 2'd0;
          nsteps_next = (req_in.op == FIC_OP_CMD_ID || req_in.op == FIC_OP_CMD_PROT) ? 2'd3 : 2'd0;
          cnt_next    = CNT_W'(SETUP_CYC);
          state_next  = FIC_SETUP;
        end
      end
      FIC_SETUP: begin
        pins_next.addr      = step_addr;
        pins_next.dq        = step_data;
        pins_next.dq_oe_n   = is_read; // low while driving
        pins_next.hv_detect = (cur_reg.op == FIC_OP_HV_ID || cur_reg.op == FIC_OP_HV_PROT);
        pins_next.ce_n      = 1'b0;
        pins_next.oe_n      = 1'b1;
        if (cnt_reg <= CNT_W'(1)) begin
          cnt_next   = CNT_W'(STROBE_CYC);
          state_next = FIC_STROBE;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      FIC_STROBE: begin
        // address stable before the strobe falls, data held past its rise
        pins_next.we_n = is_read;
        pins_next.oe_n = !is_read;
        if (cnt_reg <= CNT_W'(1)) begin
          state_next = FIC_HOLD;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      FIC_HOLD: begin
        pins_next.we_n = 1'b1;
        pins_next.oe_n = 1'b1;
        if (is_read) begin
          rd_next  = dq_s2_reg;
          rdv_next = 1'b1;
          par_next = ^dq_s2_reg;
          prot_next = dq_s2_reg[PROT_FLAG_BIT];
        end
        if ((cur_reg.op == FIC_OP_CMD_ID || cur_reg.op == FIC_OP_CMD_PROT) && step_reg == 2'd2) begin
          idm_next = 1'b1;
        end
        if (cur_reg.op == FIC_OP_EXIT_ID) begin
          idm_next = 1'b0;
        end
        state_next = FIC_NEXT;
      end
      default: begin
        pins_next.ce_n    = 1'b1;
        pins_next.dq_oe_n = 1'b1;
        if (step_reg != nsteps_reg) begin
          step_next  = step_reg + 2'd1;
          cnt_next   = CNT_W'(SETUP_CYC);
          state_next = FIC_SETUP;
        end else begin
          rdy_next   = 1'b1;
          state_next = FIC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg  <= FIC_IDLE;
      cur_reg    <= '0;
      pins_reg   <= '{addr: 20'h00000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                      dq_oe_n: 1'b1, dq: 8'h00, hv_detect: 1'b0, hv_reset: 1'b0};
      cnt_reg    <= '0;
      step_reg   <= 2'd0;
      nsteps_reg <= 2'd0;
      rd_reg     <= 8'h00;
      rdv_reg    <= 1'b0;
      par_reg    <= 1'b0;
      prot_reg   <= 1'b0;
      idm_reg    <= 1'b0;
      rdy_reg    <= 1'b1;
      rstn_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cur_reg    <= cur_next;
      pins_reg   <= pins_next;
      cnt_reg    <= cnt_next;
      step_reg   <= step_next;
      nsteps_reg <= nsteps_next;
      rd_reg     <= rd_next;
      rdv_reg    <= rdv_next;
      par_reg    <= par_next;
      prot_reg   <= prot_next;
      idm_reg    <= idm_next;
      rdy_reg    <= rdy_next;
      rstn_reg   <= rstn_next;
    end
  end

  assign pins_out      = pins_reg;
  assign req_ready_out = rdy_reg;
  assign rd_data_out   = rd_reg;
  assign rd_valid_out  = rdv_reg;
  assign parity_ok_out = par_reg;
  assign protected_out = prot_reg;
  assign id_mode_out   = idm_reg;
  assign rst_n_out     = rstn_reg;

  property p_write_gate;
    @(posedge clk_in) disable iff (rst_in)
      !pins_reg.we_n |-> (!pins_reg.ce_n && pins_reg.oe_n && !pins_reg.dq_oe_n);
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("write strobe without gate");

  property p_addr_stable;
    @(posedge clk_in) disable iff (rst_in)
      (!pins_reg.we_n && !$past(pins_reg.we_n)) |-> $stable(pins_reg.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved during strobe");

  property p_id_select;
    @(posedge clk_in) disable iff (rst_in)
      (pins_reg.hv_detect && !pins_reg.oe_n && cur_reg.op == FIC_OP_HV_ID)
        |-> (!pins_reg.addr[PROT_SEL_BIT] && !pins_reg.addr[AUTO_LOW_BIT]);
  endproperty
  a_id_select: assert property (p_id_select) else $error("id read with select bit high");

  property p_prot_select;
    @(posedge clk_in) disable iff (rst_in)
      (!pins_reg.oe_n && (cur_reg.op == FIC_OP_HV_PROT || cur_reg.op == FIC_OP_CMD_PROT))
        |-> (pins_reg.addr[PROT_SEL_BIT] && !pins_reg.addr[BYTE_SEL_BIT]);
  endproperty
  a_prot_select: assert property (p_prot_select) else $error("bad protect query address");

  property p_unlock_first;
    @(posedge clk_in) disable iff (rst_in)
      ($fell(pins_reg.we_n) && step_reg == 2'd0 && cur_reg.op == FIC_OP_CMD_ID)
        |-> (pins_reg.addr == UNLOCK1_ADDR && pins_reg.dq == UNLOCK1_DATA);
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("first unlock wrong");

  property p_exit_data;
    @(posedge clk_in) disable iff (rst_in)
      ($fell(pins_reg.we_n) && cur_reg.op == FIC_OP_EXIT_ID) |-> pins_reg.dq == CMD_RESET;
  endproperty
  a_exit_data: assert property (p_exit_data) else $error("exit without reset code");

  property p_parity;
    @(posedge clk_in) disable iff (rst_in)
      (state_reg == FIC_HOLD && is_read)
        |=> (parity_ok_out == ^rd_data_out && rd_valid_out && rd_data_out == $past(dq_s2_reg));
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag mismatch");

  property p_unprotect;
    @(posedge clk_in) disable iff (rst_in)
      unprotect_in |=> pins_reg.hv_reset;
  endproperty
  a_unprotect: assert property (p_unprotect) else $error("unprotect not driven");
endmodule

// ===== include/fic_pkg.sv
// package for the flash id and protect host controller
package fic_pkg;
  localparam int          ADDR_W       = 20;
  localparam int          DATA_W       = 8;
  localparam int          CLK_MHZ      = 50;
  localparam int          SETUP_NS     = 100;
  localparam int          STROBE_NS    = 60;
  localparam int          SETUP_CYC    = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int          STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W        = 8;
  localparam logic [19:0] UNLOCK1_ADDR = 20'h00555;
  localparam logic [19:0] UNLOCK2_ADDR = 20'h002AA;
  localparam logic [7:0]  UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  CMD_IDENT    = 8'h90;
  localparam logic [7:0]  CMD_RESET    = 8'hF0;
  localparam logic [19:0] OFS_MANUF    = 20'h00000;
  localparam logic [19:0] OFS_DEVICE   = 20'h00001;
  localparam logic [19:0] OFS_PROTECT  = 20'h00002;
  localparam int          SECT_LSB     = 13;
  localparam int          BYTE_SEL_BIT = 0;
  localparam int          PROT_SEL_BIT = 1;
  localparam int          AUTO_LOW_BIT = 6;
  localparam int          PROT_FLAG_BIT = 0;
  localparam int          PARITY_BIT   = 7;

  typedef enum logic [2:0] {
    FIC_OP_READ,
    FIC_OP_HV_ID,
    FIC_OP_HV_PROT,
    FIC_OP_CMD_ID,
    FIC_OP_CMD_PROT,
    FIC_OP_EXIT_ID,
    FIC_OP_WRITE
  } fic_op_e;

  typedef struct packed {
    fic_op_e     op;
    logic [19:0] addr;
    logic [7:0]  data;
  } fic_req_s;

  typedef struct packed {
    logic [19:0] addr;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq_oe_n;
    logic [7:0]  dq;
    logic        hv_detect;
    logic        hv_reset;
  } fic_pins_s;
endpackage

// ===== tb/fic_flash_model.sv
// behavioural top or bottom boot flash device seen from the host pins
`timescale 1ns/1ns
module fic_flash_model #(
  parameter logic [7:0]  MANUF  = 8'h02, // arbitrary value, odd parity
  parameter logic [7:0]  DEVICE = 8'h0B, // arbitrary value, odd parity
  parameter logic [18:0] PROT   = 19'h10008,
  parameter bit          BOTTOM = 1'b0,
  parameter int          PGM_NS = 1000,
  parameter int          ERS_NS = 50000
) (
  input  wire fic_pkg::fic_pins_s pins_in,
  input  wire logic               rst_n_in,
  output logic [7:0]              dq_out
);
  import fic_pkg::*;
  localparam logic [7:0] CMD_PGM  = 8'hA0;
  localparam logic [7:0] CMD_ERS  = 8'h80;
  localparam logic [7:0] CMD_SECT = 8'h30;
  logic [2:0]  step;
  logic        id_mode;
  logic [19:0] a_lat;
  logic [7:0]  last;
  logic [19:0] pa; // one programmed byte stands in for the array
  logic [7:0]  pd;
  logic        pa_ok = 1'b0;
  logic [18:0] erased = '0;
  logic [1:0]  busy = 2'h0; // 1 program status, 2 erase status
  logic [7:0]  bpd;
  logic        tog = 1'b0;
  time         busy_end = 0;
  wire         wr = ~pins_in.ce_n & ~pins_in.we_n;
  function automatic logic [4:0] sect(input logic [19:0] a);
    if (BOTTOM) begin
      if (a[19:16] != 4'h0) return {1'b0, a[19:16]} + 5'h03;
      if (a[15]) return 5'h03;
      if (a[14]) return a[13] ? 5'h02 : 5'h01;
      return 5'h00;
    end
    if (a[19:16] != 4'hF) return {1'b0, a[19:16]};
    if (!a[15]) return 5'h0F;
    if (!a[14]) return {4'h8, a[13]};
    return 5'h12;
  endfunction
  function automatic logic locked(input logic [19:0] a); // elevated reset pin lifts protection
    return PROT[sect(a)] && !pins_in.hv_reset;
  endfunction
  function automatic logic [7:0] rd(input logic [19:0] a);
    if (pins_in.hv_detect || id_mode) begin
      if (a[PROT_SEL_BIT]) return {7'h00, PROT[sect(a)]};
      return a[BYTE_SEL_BIT] ? DEVICE : MANUF; // other bits ignored
    end
    if ($time < busy_end) return (busy == 2'h1) ? {~bpd[7], 7'h00} : {1'b0, tog, 6'h00};
    if (pa_ok && a == pa) return pd;
    if (erased[sect(a)]) return 8'hFF;
    return a[7:0] ^ 8'h5A;
  endfunction
  always @(posedge wr) a_lat = pins_in.addr; // later falling edge
  always @(negedge wr or negedge rst_n_in) begin // data at earlier rising edge
    if (!rst_n_in) begin
      step <= 3'h0;
      id_mode <= 1'b0;
    end else if (step == 3'h3) begin // protected byte keeps its value
      step <= 3'h0;
      if (locked(a_lat)) begin
        bpd <= pins_in.dq;
        busy <= 2'h1;
        busy_end <= $time + PGM_NS;
      end else begin
        pa <= a_lat;
        pd <= pins_in.dq;
        pa_ok <= 1'b1;
      end
    end else if (step == 3'h6 && pins_in.dq == CMD_SECT) begin
      step <= 3'h0;
      if (locked(a_lat)) begin
        busy <= 2'h2;
        busy_end <= $time + ERS_NS;
      end else begin
        erased[sect(a_lat)] <= 1'b1;
      end
    end else if (pins_in.dq == CMD_RESET) begin
      step <= 3'h0;
      id_mode <= 1'b0;
    end else if ((step == 3'h0 || step == 3'h4) && a_lat[10:0] == UNLOCK1_ADDR[10:0]
                 && pins_in.dq == UNLOCK1_DATA) begin
      step <= step + 3'h1;
    end else if ((step == 3'h1 || step == 3'h5) && a_lat[10:0] == UNLOCK2_ADDR[10:0]
                 && pins_in.dq == UNLOCK2_DATA) begin
      step <= step + 3'h1;
    end else if (step == 3'h2 && a_lat[10:0] == UNLOCK1_ADDR[10:0] && pins_in.dq == CMD_IDENT) begin
      step <= 3'h0;
      id_mode <= 1'b1;
    end else if (step == 3'h2 && a_lat[10:0] == UNLOCK1_ADDR[10:0] && pins_in.dq == CMD_PGM) begin
      step <= 3'h3;
    end else if (step == 3'h2 && a_lat[10:0] == UNLOCK1_ADDR[10:0] && pins_in.dq == CMD_ERS) begin
      step <= 3'h4;
    end else begin
      step <= 3'h0; // bad step, or suspend and resume with no erase running, back to read
    end
  end
  always @* begin
    if (!pins_in.ce_n && !pins_in.oe_n && pins_in.dq_oe_n && rst_n_in) dq_out = rd(pins_in.addr);
    else dq_out = ~last; // no pull on the bus, so never hold a stale byte
  end
  always @(negedge pins_in.oe_n) last = rd(pins_in.addr);
  always @(posedge pins_in.oe_n) tog = ~tog; // status bit moves once per read
endmodule

// ===== tb/tb.sv
// self-checking bench for the flash id and protect host controller
`timescale 1ns/1ns
module tb;
  import fic_pkg::*;
  typedef struct packed {
    fic_op_e     op;
    logic [19:0] addr;
    logic [7:0]  exp;
    logic        rd;
    logic        idm;
  } fic_row_s;
  logic        clk_in, rst_in, req_valid_in, unprotect_in, req_ready_out, rst_n_out;
  logic        rd_valid_out, parity_ok_out, protected_out, id_mode_out, got_rd;
  localparam logic [7:0] CMD_PGM  = 8'hA0;
  localparam logic [7:0] CMD_ERS  = 8'h80;
  localparam logic [7:0] CMD_SECT = 8'h30;
  localparam logic [7:0] CMD_SUSP = 8'hB0;
  logic [7:0]  dq_in, rd_data_out, r1;
  fic_req_s    req_in;
  fic_pins_s   pins_out;
  int          n_fail, n_compared;
  fic_row_s    rows [13];
  fic_host dut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .req_valid_in(req_valid_in),
    .unprotect_in(unprotect_in), .dq_in(dq_in), .req_ready_out(req_ready_out), .pins_out(pins_out),
    .rst_n_out(rst_n_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .parity_ok_out(parity_ok_out), .protected_out(protected_out), .id_mode_out(id_mode_out));
  fic_flash_model u_flash (.pins_in(pins_out), .rst_n_in(rst_n_out), .dq_out(dq_in));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk1(input string nm, input logic got, input logic exp);
    chk8(nm, {7'h00, got}, {7'h00, exp});
  endtask
  task automatic do_op(input fic_op_e op, input logic [19:0] a, input logic [7:0] d);
    logic low;
    low = 1'b0;
    got_rd = 1'b0;
    req_in <= '{op: op, addr: a, data: d};
    req_valid_in <= 1'b1;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_in);
      if (rd_valid_out === 1'b1) got_rd = 1'b1;
      if (pins_out.we_n === 1'b0) chk1("oe_n", pins_out.oe_n, 1'b1);
      if (op == FIC_OP_HV_ID && pins_out.oe_n === 1'b0) chk1("prot_sel", pins_out.addr[PROT_SEL_BIT], 1'b0);
      if (op inside {FIC_OP_HV_ID, FIC_OP_HV_PROT} && pins_out.oe_n === 1'b0) chk1("hv", pins_out.hv_detect, 1'b1);
      if (req_ready_out === 1'b0) low = 1'b1;
      if (low && req_ready_out === 1'b1) return;
    end
    n_fail++;
    $display("[FAIL] ready expected 1 seen timeout");
    complete_run();
  endtask
  task automatic cmd3(input logic [19:0] a, input logic [7:0] d);
    do_op(FIC_OP_WRITE, UNLOCK1_ADDR, UNLOCK1_DATA);
    do_op(FIC_OP_WRITE, UNLOCK2_ADDR, UNLOCK2_DATA);
    do_op(FIC_OP_WRITE, a, d);
  endtask
  initial begin
    n_fail = 0;
    n_compared = 0;
    rst_in = 1'b1;
    req_valid_in = 1'b0;
    unprotect_in = 1'b0;
    req_in = '0;
    rows = '{
      '{FIC_OP_HV_ID, 20'h00000, 8'h02, 1'b1, 1'b0}, '{FIC_OP_HV_ID, 20'h00001, 8'h0B, 1'b1, 1'b0},
      '{FIC_OP_HV_ID, 20'hABC80, 8'h02, 1'b1, 1'b0}, '{FIC_OP_HV_ID, 20'h7A381, 8'h0B, 1'b1, 1'b0},
      '{FIC_OP_HV_PROT, 20'h30002, 8'h01, 1'b1, 1'b0}, '{FIC_OP_HV_PROT, 20'h40002, 8'h00, 1'b1, 1'b0},
      '{FIC_OP_HV_PROT, 20'hF8002, 8'h01, 1'b1, 1'b0}, '{FIC_OP_HV_PROT, 20'hFA002, 8'h00, 1'b1, 1'b0},
      '{FIC_OP_READ, 20'h00034, 8'h6E, 1'b1, 1'b0}, '{FIC_OP_CMD_ID, 20'h00001, 8'h0B, 1'b1, 1'b1},
      '{FIC_OP_READ, 20'h00000, 8'h02, 1'b1, 1'b1}, '{FIC_OP_CMD_PROT, 20'h30002, 8'h01, 1'b1, 1'b1},
      '{FIC_OP_EXIT_ID, 20'h00000, 8'h00, 1'b0, 1'b0}};
    repeat (10) @(posedge clk_in);
    chk1("ce_n", pins_out.ce_n, 1'b1);
    chk1("rst_n", rst_n_out, 1'b0);
    chk1("ready", req_ready_out, 1'b1);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    $display("reset test done");
    foreach (rows[k]) begin
      do_op(rows[k].op, rows[k].addr, 8'h00);
      chk1("id_mode", id_mode_out, rows[k].idm);
      if (rows[k].rd) begin
        chk1("rd_valid", got_rd, 1'b1);
        chk8("rd_data", rd_data_out, rows[k].exp);
        chk1("parity", parity_ok_out, ^rows[k].exp);
        chk1("protected", protected_out, rows[k].exp[0]);
      end
      $display("row %0d done", k);
    end
    do_op(FIC_OP_READ, 20'h00000, 8'h00);
    chk8("rd_data", rd_data_out, 8'h5A);
    do_op(FIC_OP_WRITE, 20'h00555, 8'hAA);
    do_op(FIC_OP_WRITE, 20'h002AA, 8'h55);
    do_op(FIC_OP_WRITE, 20'h00123, 8'h00);
    do_op(FIC_OP_WRITE, 20'h00555, 8'h90);
    do_op(FIC_OP_READ, 20'h00001, 8'h00);
    chk8("rd_data", rd_data_out, 8'h5B);
    $display("bad sequence test done");
    cmd3(UNLOCK1_ADDR, CMD_PGM);
    do_op(FIC_OP_WRITE, 20'h30010, 8'h00);
    do_op(FIC_OP_READ, 20'h30010, 8'h00);
    chk8("poll", rd_data_out, 8'h80);
    repeat (50) @(posedge clk_in);
    do_op(FIC_OP_READ, 20'h30010, 8'h00);
    chk8("rd_data", rd_data_out, 8'h4A);
    cmd3(UNLOCK1_ADDR, CMD_ERS);
    cmd3(20'h30000, CMD_SECT);
    do_op(FIC_OP_READ, 20'h30000, 8'h00);
    r1 = rd_data_out;
    do_op(FIC_OP_READ, 20'h30000, 8'h00);
    chk1("toggle", r1[6] ^ rd_data_out[6], 1'b1);
    repeat (2500) @(posedge clk_in);
    do_op(FIC_OP_READ, 20'h30000, 8'h00);
    chk8("rd_data", rd_data_out, 8'h5A);
    do_op(FIC_OP_WRITE, 20'h00000, CMD_SUSP);
    do_op(FIC_OP_READ, 20'h00034, 8'h00);
    chk8("rd_data", rd_data_out, 8'h6E);
    $display("protected sector test done");
    unprotect_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk1("hv_reset", pins_out.hv_reset, 1'b1);
    cmd3(UNLOCK1_ADDR, CMD_PGM);
    do_op(FIC_OP_WRITE, 20'h30010, 8'h3C);
    do_op(FIC_OP_READ, 20'h30010, 8'h00);
    chk8("rd_data", rd_data_out, 8'h3C);
    unprotect_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk1("hv_reset", pins_out.hv_reset, 1'b0);
    cmd3(UNLOCK1_ADDR, CMD_PGM);
    do_op(FIC_OP_WRITE, 20'h30020, 8'h3C);
    repeat (50) @(posedge clk_in);
    do_op(FIC_OP_READ, 20'h30020, 8'h00);
    chk8("rd_data", rd_data_out, 8'h7A);
    $display("unprotect test done");
    do_op(FIC_OP_CMD_ID, 20'h00000, 8'h00);
    chk1("id_mode", id_mode_out, 1'b1);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk1("id_mode", id_mode_out, 1'b0);
    chk1("rst_n", rst_n_out, 1'b0);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    do_op(FIC_OP_READ, 20'h00001, 8'h00);
    chk8("rd_data", rd_data_out, 8'h5B);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule
